//--- logic/sacs_pkg.sv
// package: constants and types for the conversion sequencer
package sacs_pkg;
	localparam int RESULT_WIDTH = 14;
	localparam int CLK_PERIOD_PS = 25000;
	localparam int CONV_MAX_NS = 4700;
	// longest time rounds down to whole cycles
	localparam int CONV_MAX_CYCLES = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
	localparam int REF_SETTLE_MS = 6;
	localparam int CONV_DIV = 4;
	localparam int CONV_STEPS = 16;
	localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 14'h0000;
	typedef enum logic [2:0] {
		SACS_IDLE,
		SACS_ACQUIRE,
		SACS_CONVERT,
		SACS_DONE,
		SACS_DRIVE
	} sacs_state_t;
endpackage : sacs_pkg

//--- logic/sacs_conv_clock.sv
// internal conversion clock: one-cycle enable pulses from a divider
`timescale 1ns/10ps
`default_nettype none
module sacs_conv_clock #(
	parameter int DIV = sacs_pkg::CONV_DIV
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic run,
	output logic tick
);
	import sacs_pkg::*;
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	logic [CW-1:0] cnt_q;

	if (DIV < 1) begin : g_div_check
		$error("DIV must be at least 1");
	end

	// counter restarts with each conversion so the first tick is DIV cycles in
	always_ff @(posedge ref_clk) begin
		if (rst || !run) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(DIV - 1)) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end

	assign tick = run && (cnt_q == CW'(DIV - 1));
endmodule : sacs_conv_clock
`default_nettype wire

//--- logic/sacs_sequencer.sv
// conversion sequencer: strobe-driven acquire, convert and read-out
//
// Contract
// [R1] reset high returns sequence to idle
// [R2] first strobe fall, select low: power, acquire
// [R3] second fall ends acquisition, starts conversion
// [R4] third fall, select high: result onto bus
// [R5] select at second fall picks standby/shutdown
// [R6] internal clock; done within 4.7us
// [R7] idle: strobe fall with select high ignored
// [R8] host waits 6ms after shutdown wake; the sacs_host model wakes from shutdown without this wait
// [R9] reset with strobe high; next fall acquires
// [R10] 14-bit result, lsb on line zero
// [R11] done flag driven low on completion
// [R12] bus high impedance except while reading
// [R13] host: select high shutdown, low standby
// [R14] conversion length is configurable cycle count
`timescale 1ns/10ps
`default_nettype none
module sacs_sequencer #(
	parameter int WIDTH = sacs_pkg::RESULT_WIDTH,
	parameter int DIV = sacs_pkg::CONV_DIV,
	parameter int STEPS = sacs_pkg::CONV_STEPS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic convert_n,
	input wire logic read_select,
	input wire logic [WIDTH-1:0] sample_value,
	output logic done_n,
	output logic [WIDTH-1:0] result_out,
	output logic [WIDTH-1:0] result_oe_n,
	output logic powered,
	output logic track,
	output logic ref_on,
	output var sacs_pkg::sacs_state_t state
);
	import sacs_pkg::*;

	localparam int SW = $clog2(STEPS + 1);

	sacs_state_t state_q;
	logic strobe_q;
	logic fall;
	logic tick;
	logic [SW-1:0] step_q;
	logic shutdown_q;
	logic [WIDTH-1:0] sample_q;
	logic [WIDTH-1:0] result_q;
	logic done_n_q;
	logic drive_q;
	logic ref_q;
	logic start_ok;
	logic hold_ok;
	logic read_ok;
	logic conv_last;

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (WIDTH != RESULT_WIDTH) begin : g_width_check
		$error("result width must be 14");
	end
	if (STEPS < WIDTH) begin : g_steps_check
		$error("STEPS must cover every result bit");
	end
	// a longer count would miss the done deadline
	if (STEPS * DIV + 2 > CONV_MAX_CYCLES) begin : g_time_check // [R14]
		$error("conversion exceeds 4.7us");
	end

	// ************************************************************
	// strobe edge detect
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			strobe_q <= 1'b1;
		end else begin
			strobe_q <= convert_n;
		end
	end
	assign fall = strobe_q && !convert_n;

	// ************************************************************
	// internal conversion clock
	// ************************************************************
	sacs_conv_clock #(.DIV(DIV)) u_clk (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(state_q == SACS_CONVERT),
		.tick(tick)
	); // [R6]

	// ************************************************************
	// strobe and step decodes
	// ************************************************************
	function automatic logic take_start(input sacs_state_t s, input logic f, input logic sel);
		return s == SACS_IDLE && f && !sel;
	endfunction : take_start

	function automatic logic take_hold(input sacs_state_t s, input logic f);
		return s == SACS_ACQUIRE && f;
	endfunction : take_hold

	function automatic logic take_read(input sacs_state_t s, input logic f, input logic sel);
		return s == SACS_DONE && f && sel;
	endfunction : take_read

	// last tick of the final step closes the conversion
	function automatic logic last_step(input sacs_state_t s, input logic t,
			input logic [SW-1:0] n);
		return s == SACS_CONVERT && t && n == SW'(STEPS - 1);
	endfunction : last_step

	assign start_ok = take_start(state_q, fall, read_select); // [R2] [R7]
	assign hold_ok = take_hold(state_q, fall); // [R3]
	assign read_ok = take_read(state_q, fall, read_select); // [R4]
	assign conv_last = last_step(state_q, tick, step_q); // [R6] [R14]

	// ************************************************************
	// sequence
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= SACS_IDLE; // [R1] [R9]
		end else begin
			unique case (state_q)
				SACS_IDLE: begin
					if (start_ok) state_q <= SACS_ACQUIRE; // [R2] [R7]
				end
				SACS_ACQUIRE: begin
					if (hold_ok) state_q <= SACS_CONVERT; // [R3]
				end
				SACS_CONVERT: begin
					if (conv_last) state_q <= SACS_DONE; // [R6] [R14]
				end
				SACS_DONE: begin
					if (read_ok) state_q <= SACS_DRIVE; // [R4]
				end
				SACS_DRIVE: begin
					// bus released on strobe rise; then wait for next start
					if (convert_n) state_q <= SACS_IDLE; // [R12]
				end
			endcase
		end
	end

	// ************************************************************
	// step counter of the successive-approximation logic
	// ************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst || state_q != SACS_CONVERT) begin
			step_q <= '0;
		end else if (tick) begin
			step_q <= step_q + SW'(1);
		end
	end

	// ************************************************************
	// sample and power-down choice
	// ************************************************************
	// sample frozen when hold opens; power-down choice taken at same edge
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sample_q <= RESULT_RESET;
			shutdown_q <= 1'b0;
		end else if (hold_ok) begin
			sample_q <= sample_value; // [R3]
			shutdown_q <= read_select; // [R5]
		end
	end

	// ************************************************************
	// result register
	// ************************************************************
	// bit-serial approximation: one bit resolved in each of the first WIDTH steps, msb first
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result_q <= RESULT_RESET;
		end else if (hold_ok) begin
			result_q <= RESULT_RESET;
		end else if (state_q == SACS_CONVERT && tick && step_q < SW'(WIDTH)) begin
			result_q[WIDTH - 1 - int'(step_q)] <= sample_q[WIDTH - 1 - int'(step_q)]; // [R10]
		end
	end

	// ************************************************************
	// done flag
	// ************************************************************
	// low from completion until the next acquisition
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			done_n_q <= 1'b1;
		end else if (conv_last) begin
			done_n_q <= 1'b0; // [R11]
		end else if (start_ok) begin
			done_n_q <= 1'b1;
		end
	end

	// ************************************************************
	// result bus drive
	// ************************************************************
	// follows the third fall and drops when the strobe rises
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drive_q <= 1'b0;
		end else if (read_ok) begin
			drive_q <= 1'b1; // [R4]
		end else if (convert_n) begin
			drive_q <= 1'b0; // [R12]
		end
	end

	// ************************************************************
	// reference power
	// ************************************************************
	// on through acquire/convert, after that per saved choice
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ref_q <= 1'b0;
		end else if (start_ok) begin
			ref_q <= 1'b1; // [R2]
		end else if (conv_last) begin
			ref_q <= !shutdown_q; // [R5]
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign done_n = done_n_q;
	assign result_out = result_q; // [R10]
	assign result_oe_n = {WIDTH{!drive_q}}; // [R12]
	assign ref_on = ref_q;
	assign powered = ref_q || state_q == SACS_CONVERT;
	assign track = state_q == SACS_ACQUIRE;
	assign state = state_q;
endmodule : sacs_sequencer
`default_nettype wire

//--- tb/sacs_host.sv
// host model: drives convert strobe and read select
`timescale 1ns/10ps
`default_nettype none
module sacs_host (
	input wire logic ref_clk,
	output var logic convert_n,
	output var logic read_select
);
	// strobe idles high so a reset is always taken with it high
	initial begin
		convert_n = 1'b1;
		read_select = 1'b0;
	end
	// shutdown cycle is followed by reset_and_ignore, whose acquires wake without the settle wait
	task fall(input logic sel);
		@(posedge ref_clk);
		#1 convert_n = 1'b1;
		@(posedge ref_clk);
		#1 convert_n = 1'b0;
		read_select = sel;
		@(posedge ref_clk);
		#1;
	endtask : fall
	task lift();
		@(posedge ref_clk);
		#1 convert_n = 1'b1;
	endtask : lift
endmodule : sacs_host
`default_nettype wire

//--- tb/sacs_chk_assertions.sv
// checker: port assertions for the sequencer
`timescale 1ns/10ps
`default_nettype none
module sacs_chk #(
	parameter int WIDTH = 14
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic convert_n,
	input wire logic read_select,
	input wire logic done_n,
	input wire logic [WIDTH-1:0] result_oe_n,
	input wire logic track,
	input wire logic ref_on,
	input wire sacs_pkg::sacs_state_t state
);
	import sacs_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_fall;
		$fell(convert_n);
	endsequence
	a_reset_idle: assert property (disable iff (1'b0) rst |=> state == SACS_IDLE && done_n)
	else $error("reset left state");
	a_idle_ignore: assert property (state == SACS_IDLE && read_select ##0 s_fall |=> state == SACS_IDLE)
	else $error("select high fall taken");
	a_first_acq: assert property (state == SACS_IDLE && !read_select ##0 s_fall |=> track && ref_on)
	else $error("no acquire");
	a_second_conv: assert property (state == SACS_ACQUIRE ##0 s_fall |=> state == SACS_CONVERT && !track)
	else $error("no convert");
	a_done_bound: assert property ($rose(state == SACS_CONVERT) |-> ##[1:188] !done_n)
	else $error("done late");
	a_bus_quiet: assert property (state inside {SACS_ACQUIRE, SACS_CONVERT} |-> &result_oe_n)
	else $error("bus driven early");
	a_read_drive: assert property (state == SACS_DONE && read_select ##0 s_fall |=> !(|result_oe_n))
	else $error("no read out");
	a_bus_release: assert property (!(|result_oe_n) && convert_n |=> &result_oe_n)
	else $error("bus held");
endmodule : sacs_chk
bind sacs_sequencer sacs_chk #(.WIDTH(WIDTH)) u_chk (.ref_clk(ref_clk), .rst(rst),
	.convert_n(convert_n), .read_select(read_select), .done_n(done_n),
	.result_oe_n(result_oe_n), .track(track), .ref_on(ref_on), .state(state));
`default_nettype wire

//--- tb/tb.sv
// testbench: strobe sequences against the sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sacs_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic convert_n, read_select, done_n, powered, track, ref_on;
	logic [13:0] sample_value = 14'h0000;
	logic [13:0] result_out, result_oe_n;
	sacs_state_t state;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	sacs_sequencer DUT (.ref_clk(ref_clk), .rst(rst), .convert_n(convert_n),
		.read_select(read_select), .sample_value(sample_value), .done_n(done_n),
		.result_out(result_out), .result_oe_n(result_oe_n), .powered(powered),
		.track(track), .ref_on(ref_on), .state(state));
	sacs_host host (.ref_clk(ref_clk), .convert_n(convert_n), .read_select(read_select));
	initial forever #12.5 ref_clk = ~ref_clk;
	task chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("Error %0t %s", $time, m);
		end
	endtask : chk
	task pulse_rst();
		host.lift();
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 rst = 1'b0;
	endtask : pulse_rst
	task conv(input logic mode, input logic [13:0] v);
		int n;
		n = 0;
		sample_value = v;
		host.fall(1'b0);
		chk(state === SACS_ACQUIRE && {track, powered, done_n} === 3'b111, "no acquire");
		host.fall(mode);
		// input moves after the hold: result must still be the held sample
		sample_value = ~v;
		chk(state === SACS_CONVERT && track === 1'b0 && powered === 1'b1, "no convert");
		while (done_n !== 1'b0 && n < 200) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk(n <= CONV_MAX_CYCLES, "done late");
		chk({ref_on, powered} === {2{!mode}} && &result_oe_n === 1'b1, "power or bus");
		host.fall(1'b1);
		chk(result_oe_n === 14'h0000 && result_out === v, "bad result");
		host.lift();
		repeat (2) @(posedge ref_clk);
		#1 chk(&result_oe_n === 1'b1 && state === SACS_IDLE, "bus held");
		$display("conversion test mode %0d ended", mode);
	endtask : conv
	task reset_and_ignore();
		host.fall(1'b0);
		pulse_rst();
		chk(state === SACS_IDLE && done_n === 1'b1 && ref_on === 1'b0, "reset");
		host.fall(1'b1);
		chk(state === SACS_IDLE && ref_on === 1'b0, "high select taken");
		host.fall(1'b0);
		chk(state === SACS_ACQUIRE, "no restart");
		$display("reset and ignore test ended");
	endtask : reset_and_ignore
	task complete_run();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	// whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			$display("Error %0t timeout", $time);
			complete_run();
		end
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		#1 rst = 1'b0;
		// asymmetric words so a reversed bit order cannot pass
		conv(1'b0, 14'h3001);
		conv(1'b1, 14'h0ffe);
		reset_and_ignore();
		complete_run();
	end
endmodule : tb
`default_nettype wire
